// file: design/nmhl_map.vh
/*
 * Opcode and field constants for the negative multiply-accumulate
 * halfword and NOR/OR execution datapath.
 * Assumes the includer handles instruction fetch and register file.
 */
`ifndef NMHL_MAP_VH
`define NMHL_MAP_VH

// ****************************************
// Primary and extended operation codes
// ****************************************
`define NMHL_PRI_MAC 6'h04
`define NMHL_PRI_LOG 6'h1f
`define NMHL_XO_CHW 9'h0ae
`define NMHL_XO_CHWS 9'h0ee
`define NMHL_XO_HHW 9'h02e
`define NMHL_XO_HHWS 9'h06e
`define NMHL_XO_LHW 9'h1ae
`define NMHL_XO_LHWS 9'h1ee
`define NMHL_XO_NOR 10'h07c
`define NMHL_XO_OR 10'h1bc

// ****************************************
// Condition field bit positions (4-bit field, bit 3 = less-than)
// ****************************************
`define NMHL_CR_LT 3
`define NMHL_CR_GT 2
`define NMHL_CR_EQ 1
`define NMHL_CR_SO 0

// ****************************************
// Saturation limits and reset values
// ****************************************
`define NMHL_SAT_MAX 32'h7fffffff
`define NMHL_SAT_MIN 32'h80000000
`define NMHL_RST_WORD 32'h00000000
`define NMHL_RST_CR 4'h0

`endif

// file: design/nmhl_unit.v
/*
 * Execution datapath: negative multiply-accumulate halfword forms
 * (modulo and saturating, cross/high/low) plus two-operand NOR and OR.
 * Assumes the core supplies decoded fields and register operands with
 * a one-cycle issue strobe, and writes back the registered results.
 * Software status/mask registers sit on a plain strobe port.
 */
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
// Overview of operation
// - High-high modulo: signed upper halfwords, product subtracted, low 32 kept.
// - High-high saturating: same negated product, result clamped on overflow.
// - Low-low modulo: signed lower halfwords, product subtracted, low 32 kept.
// - Low-low saturating: lower halfword product, negated, clamped result.
// - Cross saturating: multiplicand low half times multiplier high half.
// - Overflow when addends share a sign unlike the sum; clamp by old sign.
// - Saturating forms without overflow store the low 32 sum bits.
// - Negated product plus accumulator forms a 33-bit intermediate sum.
// - NOR writes the complement of logic input OR multiplier register.
// - NOR with the same register twice gives its one's complement.
// - OR decodes extended code 444 under primary opcode 31.
// - OR writes logic input OR multiplier register to destination.
`timescale 1ns/10ps
`default_nettype none
`include "nmhl_map.vh"

module nmhl_unit (
	// Clock and reset
	input wire mclk,
	input wire rst_n,
	// Issue port
	input wire issue,
	input wire [5:0] pri_op,
	input wire [9:0] ext_op,
	input wire oe_flag,
	input wire cond_update_flag,
	input wire [31:0] multiplicand_reg,
	input wire [31:0] multiplier_reg,
	input wire [31:0] logic_in_reg,
	input wire [31:0] acc_reg,
	input wire sticky_in,
	// Result port
	output reg [31:0] result_ff,
	output reg result_valid_ff,
	output reg illegal_ff,
	output reg [3:0] cond_field_zero_ff,
	output reg cond_valid_ff,
	output reg arith_wrap_bit_ff,
	output reg sticky_ff,
	output reg wrap_valid_ff,
	// Register port
	input wire [3:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata_ff,
	// Interrupt
	output wire irq
);

	localparam [3:0] ADDR_STAT = 4'h0;
	localparam [3:0] ADDR_MASK = 4'h4;
	localparam [3:0] ADDR_LAST = 4'h8;

	// ****************************************
	// Decode
	// ****************************************
	wire is_mac = (pri_op == `NMHL_PRI_MAC);
	wire [8:0] xo9 = ext_op[8:0];
	wire op_chw = is_mac && (xo9 == `NMHL_XO_CHW);
	wire op_chws = is_mac && (xo9 == `NMHL_XO_CHWS);
	wire op_hhw = is_mac && (xo9 == `NMHL_XO_HHW);
	wire op_hhws = is_mac && (xo9 == `NMHL_XO_HHWS);
	wire op_lhw = is_mac && (xo9 == `NMHL_XO_LHW);
	wire op_lhws = is_mac && (xo9 == `NMHL_XO_LHWS);
	wire is_log = (pri_op == `NMHL_PRI_LOG);
	wire op_nor = is_log && (ext_op == `NMHL_XO_NOR);
	wire op_or = is_log && (ext_op == `NMHL_XO_OR);
	wire any_mac = op_chw | op_chws | op_hhw | op_hhws | op_lhw | op_lhws;
	wire sat_form = op_chws | op_hhws | op_lhws;
	wire legal = any_mac | op_nor | op_or;

	// ****************************************
	// Halfword selection and product
	// ****************************************
	// Bit 0 of the big-endian numbering is bit 31 here: upper half is [31:16]
	reg [15:0] half_a;
	reg [15:0] half_b;
	always @* begin
		half_a = multiplicand_reg[15:0];
		half_b = multiplier_reg[15:0];
		if (op_hhw | op_hhws) begin
			half_a = multiplicand_reg[31:16];
			half_b = multiplier_reg[31:16];
		end else if (op_chw | op_chws) begin
			half_a = multiplicand_reg[15:0];
			half_b = multiplier_reg[31:16];
		end
	end

	wire signed [31:0] prod = $signed(half_a) * $signed(half_b);
	// 16x16 signed product never reaches -2^31, so negation cannot wrap
	wire [31:0] nprod = 32'h0 - prod;
	// Sign-extended 33-bit sum of negated product and accumulator
	wire [32:0] temp = {nprod[31], nprod} + {acc_reg[31], acc_reg};
	wire ovf = (nprod[31] == acc_reg[31]) && (acc_reg[31] != temp[31]);

	reg [31:0] mac_res;
	always @* begin
		mac_res = temp[31:0];
		if (sat_form && ovf) begin
			mac_res = acc_reg[31] ? `NMHL_SAT_MIN : `NMHL_SAT_MAX;
		end
	end

	// Same register on both inputs collapses to plain complement
	wire [31:0] or_val = logic_in_reg | multiplier_reg;
	wire [31:0] nor_val = ~or_val;

	reg [31:0] nxt_result;
	always @* begin
		if (any_mac) begin
			nxt_result = mac_res;
		end else if (op_nor) begin
			nxt_result = nor_val;
		end else if (op_or) begin
			nxt_result = or_val;
		end else begin
			nxt_result = `NMHL_RST_WORD;
		end
	end

	// Overflow of modulo forms is also the 33-bit signed overflow
	wire nxt_ov = any_mac & ovf;
	wire nxt_so = sticky_in | nxt_ov;
	reg [3:0] nxt_cr;
	always @* begin
		nxt_cr = `NMHL_RST_CR;
		nxt_cr[`NMHL_CR_LT] = nxt_result[31];
		nxt_cr[`NMHL_CR_GT] = ~nxt_result[31] & (|nxt_result);
		nxt_cr[`NMHL_CR_EQ] = ~(|nxt_result);
		nxt_cr[`NMHL_CR_SO] = (any_mac & oe_flag) ? nxt_so : sticky_in;
	end

	// ****************************************
	// Result registers
	// ****************************************
	always @(posedge mclk) begin
		if (!rst_n) begin
			result_ff <= `NMHL_RST_WORD;
			result_valid_ff <= 1'b0;
			illegal_ff <= 1'b0;
			cond_field_zero_ff <= `NMHL_RST_CR;
			cond_valid_ff <= 1'b0;
			arith_wrap_bit_ff <= 1'b0;
			sticky_ff <= 1'b0;
			wrap_valid_ff <= 1'b0;
		end else begin
			result_valid_ff <= issue & legal;
			illegal_ff <= issue & ~legal;
			cond_valid_ff <= issue & legal & cond_update_flag;
			wrap_valid_ff <= issue & any_mac & oe_flag;
			if (issue & legal) begin
				result_ff <= nxt_result;
				if (cond_update_flag) begin
					cond_field_zero_ff <= nxt_cr;
				end
				if (any_mac & oe_flag) begin
					arith_wrap_bit_ff <= nxt_ov;
					sticky_ff <= nxt_so;
				end
			end
		end
	end

	// ****************************************
	// Status, mask and interrupt
	// ****************************************
	// Status: bit0 completion, bit1 overflow, bit2 saturation, bit3 illegal
	reg [3:0] stat_ff;
	reg [3:0] mask_ff;
	reg [31:0] last_ff;
	wire [3:0] ev = {issue & ~legal, issue & sat_form & ovf,
		issue & nxt_ov, issue & legal};
	wire stat_rd = reg_rd && (reg_addr == ADDR_STAT);

	always @(posedge mclk) begin
		if (!rst_n) begin
			stat_ff <= 4'h0;
			mask_ff <= 4'h0;
			last_ff <= `NMHL_RST_WORD;
			reg_rdata_ff <= 32'h0;
		end else begin
			// New events win over the clear-on-read
			stat_ff <= (stat_rd ? 4'h0 : stat_ff) | ev;
			if (reg_wr && (reg_addr == ADDR_MASK)) begin
				mask_ff <= reg_wdata[3:0];
			end
			if (issue & legal) begin
				last_ff <= nxt_result;
			end
			if (reg_rd) begin
				case (reg_addr)
					ADDR_STAT: reg_rdata_ff <= {28'h0, stat_ff};
					ADDR_MASK: reg_rdata_ff <= {28'h0, mask_ff};
					ADDR_LAST: reg_rdata_ff <= last_ff;
					default: reg_rdata_ff <= 32'h0;
				endcase
			end else begin
				reg_rdata_ff <= 32'h0;
			end
		end
	end

	assign irq = |(stat_ff & mask_ff);

endmodule // nmhl_unit
`default_nettype wire

// file: verification/nmhl_unit_props.sv
/*
 * Checker for the MAC halfword and NOR/OR datapath ports.
 * Assumes one clock domain with synchronous active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none
module nmhl_unit_props (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Issue port
	input wire logic issue,
	input wire logic [5:0] pri_op,
	input wire logic [9:0] ext_op,
	input wire logic cond_update_flag,
	input wire logic oe_flag,
	input wire logic [31:0] multiplicand_reg,
	input wire logic [31:0] multiplier_reg,
	input wire logic [31:0] logic_in_reg,
	input wire logic [31:0] acc_reg,
	// Result and register port
	input wire logic [31:0] result_ff,
	input wire logic result_valid_ff,
	input wire logic illegal_ff,
	input wire logic cond_valid_ff,
	input wire logic wrap_valid_ff,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata_ff,
	input wire logic irq
);
	logic signed [15:0] ha, hb;
	logic signed [31:0] np;
	logic [32:0] tp;
	logic [31:0] lor, ex;
	logic ov, mac, lg;
	// Codes with bits 8:6 = 10x are not MAC forms
	assign mac = pri_op == 6'h04 && ext_op[5:0] == 6'h2e
		&& !(ext_op[8] && !ext_op[7]);
	assign lg = pri_op == 6'h1f && (ext_op == 10'h07c || ext_op == 10'h1bc);
	assign ha = ext_op[7] ? multiplicand_reg[15:0] : multiplicand_reg[31:16];
	assign hb = ext_op[8] ? multiplier_reg[15:0] : multiplier_reg[31:16];
	assign np = -(ha * hb);
	assign tp = {np[31], np} + {acc_reg[31], acc_reg};
	assign ov = np[31] == acc_reg[31] && acc_reg[31] != tp[31];
	assign lor = logic_in_reg | multiplier_reg;
	assign ex = !mac ? (ext_op[8] ? lor : ~lor) : (ext_op[6] && ov) ?
		{acc_reg[31], {31{~acc_reg[31]}}} : tp[31:0];
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	property p_res; issue && (mac || lg) |=> result_ff == $past(ex); endproperty
	a_res: assert property (p_res) else $error("wrong result");
	property p_valid; issue && (mac || lg) |=> result_valid_ff; endproperty
	a_valid: assert property (p_valid) else $error("no valid");
	property p_ill; issue && !mac && !lg |=> illegal_ff && !result_valid_ff;
	endproperty
	a_ill: assert property (p_ill) else $error("no refusal");
	property p_idle; !issue |=> !result_valid_ff && !illegal_ff; endproperty
	a_idle: assert property (p_idle) else $error("stray pulse");
	property p_hold; !(issue && (mac || lg)) |=> $stable(result_ff);
	endproperty
	a_hold: assert property (p_hold) else $error("result moved");
	property p_cond;
		issue && (mac || lg) |=> cond_valid_ff == $past(cond_update_flag);
	endproperty
	a_cond: assert property (p_cond) else $error("cond pulse");
	property p_wrap; issue |=> wrap_valid_ff == $past(mac && oe_flag);
	endproperty
	a_wrap: assert property (p_wrap) else $error("wrap pulse");
	property p_rd; !reg_rd |=> reg_rdata_ff == 32'h0; endproperty
	a_rd: assert property (p_rd) else $error("read data idle");
	c_sat: cover property (issue && mac && ext_op[6] && ov);
	c_ill: cover property (illegal_ff);
	c_irq: cover property (irq);
endmodule // nmhl_unit_props
bind nmhl_unit nmhl_unit_props u_props (.mclk, .rst_n, .issue, .pri_op,
	.ext_op, .cond_update_flag, .oe_flag, .multiplicand_reg, .multiplier_reg,
	.logic_in_reg, .acc_reg, .result_ff, .result_valid_ff, .illegal_ff,
	.cond_valid_ff, .wrap_valid_ff, .reg_rd, .reg_rdata_ff, .irq);
`default_nettype wire

// file: verification/nmhl_unit_tb.sv
/*
 * Self-checking bench: table of operations, then refusal and registers.
 * Assumes the checker is bound to the unit separately.
 */
`timescale 1ns/10ps
`default_nettype none
module nmhl_unit_tb;
	typedef struct {logic [9:0] x; logic [31:0] a, b, s, c, e; logic [3:0] f;}
		nmhl_row_t;
	logic mclk = 0, rst_n = 0, issue = 0, oe_flag = 1, cond_update_flag = 1;
	logic sticky_in = 0, reg_wr = 0, reg_rd = 0;
	logic [5:0] pri_op = 0;
	logic [9:0] ext_op = 0;
	logic [3:0] reg_addr = 0;
	logic [31:0] multiplicand_reg = 0, multiplier_reg = 0, logic_in_reg = 0;
	logic [31:0] acc_reg = 0, reg_wdata = 0;
	wire [31:0] result_ff, reg_rdata_ff;
	wire [3:0] cond_field_zero_ff;
	wire result_valid_ff, illegal_ff, cond_valid_ff, arith_wrap_bit_ff;
	wire sticky_ff, wrap_valid_ff, irq;
	int fails = 0, samples_checked = 0;
	nmhl_row_t rows[9] = '{
		'{10'h02e,32'h30000,32'h40000,32'h0,32'h10,32'h4,4'h4},
		'{10'h06e,32'h7fff0000,32'h80000000,32'h0,32'h7fffffff,32'h7fffffff,4'h5},
		'{10'h1ae,32'hfffe,32'h3,32'h0,32'h7ffffffe,32'h80000004,4'h9},
		'{10'h1ee,32'h7fff,32'h7fff,32'h0,32'h80000000,32'h80000000,4'h9},
		'{10'h0ee,32'h12340002,32'h59999,32'h0,32'h64,32'h5a,4'h4},
		'{10'h0ae,32'h1fffd,32'h70000,32'h0,32'h0,32'h15,4'h4},
		'{10'h07c,32'h0,32'hff00f0,32'hf0f0000,32'h0,32'hf000ff0f,4'h8},
		'{10'h07c,32'h0,32'h12345678,32'h12345678,32'h0,32'hedcba987,4'h8},
		'{10'h1bc,32'h0,32'h5000010,32'ha0000001,32'h0,32'ha5000011,4'h8}};
	nmhl_unit dut_u (.mclk, .rst_n, .issue, .pri_op, .ext_op, .oe_flag,
		.cond_update_flag, .multiplicand_reg, .multiplier_reg, .logic_in_reg,
		.acc_reg, .sticky_in, .result_ff, .result_valid_ff, .illegal_ff,
		.cond_field_zero_ff, .cond_valid_ff, .arith_wrap_bit_ff, .sticky_ff,
		.wrap_valid_ff, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata_ff, .irq);
	always #10 mclk = ~mclk;
	task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge mclk);
		reg_addr <= a; reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk("rdata", reg_rdata_ff, e);
	endtask
	task print_verdict;
		$display("checks %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// *****
	// Main sequence
	// *****
	initial begin
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		#1 chk("reset result", result_ff, 32'h0);
		chk("reset irq", irq, 1'b0);
		foreach (rows[i]) begin
			@(posedge mclk);
			// Bit 1 of the extended code tells MAC forms from logic ones
			pri_op <= rows[i].x[1] ? 6'h04 : 6'h1f;
			ext_op <= rows[i].x; issue <= 1'b1;
			multiplicand_reg <= rows[i].a; multiplier_reg <= rows[i].b;
			logic_in_reg <= rows[i].s; acc_reg <= rows[i].c;
			@(posedge mclk);
			issue <= 1'b0;
			#1 chk("result", result_ff, rows[i].e);
			chk("cond", cond_field_zero_ff, rows[i].f);
			if (rows[i].x[1])
				chk("wrap", arith_wrap_bit_ff, rows[i].f[0]);
		end
		@(posedge mclk);
		pri_op <= 6'h04; ext_op <= 10'h12e; issue <= 1'b1;
		@(posedge mclk);
		issue <= 1'b0;
		#1 chk("illegal", illegal_ff, 1'b1);
		chk("kept", result_ff, 32'ha5000011);
		chk("masked irq", irq, 1'b0);
		wr(4'h4, 32'hf);
		chk("irq", irq, 1'b1);
		rd(4'h4, 32'hf);
		rd(4'h0, 32'hf);
		rd(4'h0, 32'h0);
		chk("cleared irq", irq, 1'b0);
		rd(4'hc, 32'h0);
		rd(4'h8, 32'ha5000011);
		print_verdict;
	end
	initial begin
		repeat (2000) @(posedge mclk);
		fails++;
		print_verdict;
	end
endmodule // nmhl_unit_tb
`default_nettype wire
